// file: core/mtr_fault_pkg.sv
// Constants, field layout and types for the motor fault manager.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package mtr_fault_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RST_MIN_NS  = 1000;
  localparam int RST_MIN_CYC   = (T_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RETRY_US    = 5000;
  localparam int RETRY_CYC     = T_RETRY_US * 1000 / CLK_PERIOD_NS;
  localparam int T_LK_RETRY_US = 5000;
  localparam int LK_RETRY_CYC  = T_LK_RETRY_US * 1000 / CLK_PERIOD_NS;
  localparam int T_LK_DET_US   = 1000000;
  localparam int LK_DET_CYC    = T_LK_DET_US * 1000 / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR  = 8'h08;

  // Control register fields
  localparam int CTRL_W        = 12;
  localparam int CTRL_OVERVOLTAGE_PROTECT_EN   = 0;
  localparam int CTRL_SER_DIS  = 1;
  localparam int CTRL_THERMAL_WARNING_REPORT_EN  = 2;
  localparam int CTRL_OCP_LSB  = 3;
  localparam int CTRL_LOCK_LSB = 5;
  localparam int CTRL_FG_LSB   = 7;
  localparam int CTRL_ADV_LSB  = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

  // Status register fields
  localparam int ST_POWER_ON_STATUS_BIT = 0;
  localparam int ST_CPUV = 1;
  localparam int ST_OV   = 2;
  localparam int ST_OCP  = 3;
  localparam int ST_BKUV = 4;
  localparam int ST_BKOC = 5;
  localparam int ST_SER  = 6;
  localparam int ST_OTP  = 7;
  localparam int ST_LOCK = 8;
  localparam int ST_OTW  = 9;
  localparam int ST_OTS  = 10;
  localparam int ST_FLT  = 11;
  localparam int ST_FET  = 12;

  // Positions inside the synchronised input vector
  localparam int SY_VMUV = 0;
  localparam int SY_AVUV = 1;
  localparam int SY_BKUV = 2;
  localparam int SY_CPUV = 3;
  localparam int SY_OV   = 4;
  localparam int SY_OTP  = 5;
  localparam int SY_OTW  = 6;
  localparam int SY_OTSD = 7;
  localparam int SY_BKOC = 8;
  localparam int SY_SLP  = 9;
  localparam int SY_OCP  = 10;
  localparam int SY_ADV  = 16;
  localparam int SY_HW   = 19;
  localparam int SY_W    = 20;

  // Fault response selections
  typedef enum logic [1:0] {
    RESP_LATCH  = 2'b00,
    RESP_RETRY  = 2'b01,
    RESP_REPORT = 2'b10,
    RESP_NONE   = 2'b11
  } resp_t;

  // Protection handler states
  typedef enum logic [1:0] {
    P_OK     = 2'b00,
    P_LATCH  = 2'b01,
    P_RETRY  = 2'b11,
    P_REPORT = 2'b10
  } prot_t;

endpackage

// file: core/speed_pulse_gen.sv
// Speed feedback pulse generator from the three Hall inputs.
// Assumes Hall inputs are asynchronous; output is an open-drain enable.
`timescale 1ns/100ps
module speed_pulse_gen
  import mtr_fault_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  // Hall inputs and division select
  input  wire logic [2:0] hall_in,
  input  wire logic [1:0] div_sel_in,
  // Edge pulse and open-drain enable
  output logic            hall_edge_out,
  output logic            speed_oe_out
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] prev;
    logic [2:0] cnt;
    logic       lvl;
    logic       oe;
    logic       edge_p;
  } sp_t;

  sp_t st_ff, nxt_st;

  // Synchronise, detect any Hall change, divide and toggle
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.s1     = hall_in;
    nxt_st.s2     = st_ff.s1;
    nxt_st.prev   = st_ff.s2;
    nxt_st.edge_p = |(st_ff.s2 ^ st_ff.prev);
    if (nxt_st.edge_p) begin
      if (st_ff.cnt >= 3'((4'd1 << div_sel_in) - 4'd1)) begin
        nxt_st.cnt = 3'd0;
        nxt_st.lvl = ~st_ff.lvl;
      end else begin
        nxt_st.cnt = st_ff.cnt + 3'd1;
      end
    end
    nxt_st.oe = ~nxt_st.lvl;
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= '{s1: 3'h0, s2: 3'h0, prev: 3'h0, cnt: 3'h0, lvl: 1'b1,
                 oe: 1'b0, edge_p: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hall_edge_out = st_ff.edge_p;
  assign speed_oe_out  = st_ff.oe;

endmodule

// file: core/mtr_fault_mgr.sv
// Fault supervision, fault pin, advance angle and speed feedback.
// Assumes comparator inputs are asynchronous and an AXI4-Lite master.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module mtr_fault_mgr
  import mtr_fault_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES    = RETRY_CYC,
  parameter int unsigned LK_RETRY_CYCLES = LK_RETRY_CYC,
  parameter int unsigned LK_DET_CYCLES   = LK_DET_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Comparator and pin inputs, asynchronous
  input  wire logic [9:0]  cmp_in,
  input  wire logic [5:0]  fet_ocp_in,
  input  wire logic [2:0]  adv_level_in,
  input  wire logic        hw_variant_in,
  input  wire logic [2:0]  hall_in,
  // Serial interface error pulse, same clock
  input  wire logic        serial_err_in,
  // Drive control outputs
  output logic             bridge_hiz_out,
  output logic             pump_en_out,
  output logic             logic_en_out,
  output logic             regulator_en_out,
  output logic             fault_out_n,
  output logic [2:0]       advance_angle_out,
  output logic             speed_pulse_oe_out
);

  typedef struct packed {
    logic [SY_W-1:0]   s1;
    logic [SY_W-1:0]   s2;
    logic              awrdy;
    logic              aw_ok;
    logic [7:0]        aw_a;
    logic              wrdy;
    logic              w_ok;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [CTRL_W-1:0] ctrl;
    logic              clr;
    logic              power_on_status_bit;
    logic              cpuvf;
    logic              ovf;
    logic              ocpf;
    logic [5:0]        fetf;
    logic              bkuvf;
    logic              bkocf;
    logic              serf;
    logic              otpf;
    logic              lockf;
    logic              otwf;
    logic              otsf;
    prot_t             ocp_st;
    prot_t             lk_st;
    logic [31:0]       ocp_cnt;
    logic [31:0]       lk_cnt;
    logic [31:0]       bk_cnt;
    logic              bk_retry;
    logic [31:0]       stall_cnt;
    logic [31:0]       slp_cnt;
    logic              hiz;
    logic              pump_en;
    logic              logic_en;
    logic              reg_en;
    logic              fault_n;
    logic [2:0]        adv;
  } st_t;

  st_t st_ff, nxt_st;

  logic hall_edge;
  logic slp_clr;
  logic clear_any;
  logic hw;
  logic ov_en;
  logic logic_off;
  logic ocp_any;
  logic lk_evt;
  resp_t overcurrent_response_sel;
  resp_t lk_mode;
  logic [1:0] fg_sel;

  // Response select used by both handlers
  function automatic resp_t eff_mode(input logic hw_v, input logic [1:0] fld);
    eff_mode = hw_v ? RESP_LATCH : resp_t'(fld);
  endfunction

  // Hall speed pulse output and edge detection
  speed_pulse_gen u_speed (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .hall_in       (hall_in),
    .div_sel_in    (fg_sel),
    .hall_edge_out (hall_edge),
    .speed_oe_out  (speed_pulse_oe_out)
  );

  // Effective settings and qualified events
  always_comb begin
    hw        = st_ff.s2[SY_HW];
    ov_en     = hw | st_ff.ctrl[CTRL_OVERVOLTAGE_PROTECT_EN];
    overcurrent_response_sel  = eff_mode(hw, st_ff.ctrl[CTRL_OCP_LSB +: 2]);
    lk_mode   = eff_mode(hw, st_ff.ctrl[CTRL_LOCK_LSB +: 2]);
    fg_sel    = hw ? 2'b00 : st_ff.ctrl[CTRL_FG_LSB +: 2];
    logic_off = st_ff.s2[SY_VMUV] | st_ff.s2[SY_AVUV];
    ocp_any   = |st_ff.s2[SY_OCP +: 6];
    slp_clr   = st_ff.s2[SY_SLP] && (st_ff.slp_cnt >= 32'(RST_MIN_CYC));
    clear_any = st_ff.clr | slp_clr;
    lk_evt    = st_ff.stall_cnt >= 32'(LK_DET_CYCLES - 1);
  end

  // Next state: bus slave, fault handlers and outputs
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = {hw_variant_in, adv_level_in, fet_ocp_in, cmp_in};
    nxt_st.s2  = st_ff.s1;
    nxt_st.clr = 1'b0;

    // Write address and data taken in either order
    if (s_axi_awvalid_in && st_ff.awrdy) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw_a  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st_ff.wrdy) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.w_d  = s_axi_wdata_in;
      nxt_st.w_s  = s_axi_wstrb_in;
    end
    if (st_ff.aw_ok && st_ff.w_ok) begin
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = 2'b00;
      if (st_ff.aw_a == ADDR_CTRL) begin
        if (st_ff.w_s[0]) nxt_st.ctrl[7:0] = st_ff.w_d[7:0];
        if (st_ff.w_s[1]) nxt_st.ctrl[CTRL_W-1:8] = st_ff.w_d[CTRL_W-1:8];
      end else if (st_ff.aw_a == ADDR_CLEAR) begin
        nxt_st.clr = st_ff.w_s[0] & st_ff.w_d[0];
      end else if (st_ff.aw_a != ADDR_STATUS) begin
        nxt_st.bresp = 2'b10;
      end
    end
    if (st_ff.bvalid && s_axi_bready_in) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awrdy = !nxt_st.aw_ok && !nxt_st.bvalid && !(st_ff.aw_ok && st_ff.w_ok);
    nxt_st.wrdy  = !nxt_st.w_ok && !nxt_st.bvalid && !(st_ff.aw_ok && st_ff.w_ok);

    // Read: one register per aligned word
    if (s_axi_arvalid_in && st_ff.arrdy) begin
      nxt_st.arrdy  = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = 2'b00;
      nxt_st.rdata  = 32'h0000_0000;
      if (s_axi_araddr_in == ADDR_CTRL) begin
        nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
      end else if (s_axi_araddr_in == ADDR_STATUS) begin
        nxt_st.rdata[ST_POWER_ON_STATUS_BIT]      = st_ff.power_on_status_bit;
        nxt_st.rdata[ST_CPUV]      = st_ff.cpuvf;
        nxt_st.rdata[ST_OV]        = st_ff.ovf;
        nxt_st.rdata[ST_OCP]       = st_ff.ocpf;
        nxt_st.rdata[ST_BKUV]      = st_ff.bkuvf;
        nxt_st.rdata[ST_BKOC]      = st_ff.bkocf;
        nxt_st.rdata[ST_SER]       = st_ff.serf;
        nxt_st.rdata[ST_OTP]       = st_ff.otpf;
        nxt_st.rdata[ST_LOCK]      = st_ff.lockf;
        nxt_st.rdata[ST_OTW]       = st_ff.otwf;
        nxt_st.rdata[ST_OTS]       = st_ff.otsf;
        nxt_st.rdata[ST_FLT]       = ~st_ff.fault_n;
        nxt_st.rdata[ST_FET +: 6]  = st_ff.fetf;
      end else if (s_axi_araddr_in != ADDR_CLEAR) begin
        nxt_st.rresp = 2'b10;
      end
    end
    if (st_ff.rvalid && s_axi_rready_in) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arrdy  = 1'b1;
    end

    // Sleep pin low time, judged on release
    if (!st_ff.s2[SY_SLP]) begin
      if (st_ff.slp_cnt < 32'(RST_MIN_CYC)) nxt_st.slp_cnt = st_ff.slp_cnt + 32'd1;
    end else begin
      nxt_st.slp_cnt = 32'd0;
    end

    nxt_st.power_on_status_bit  = logic_off ? 1'b0 : (clear_any | st_ff.power_on_status_bit);
    nxt_st.cpuvf = st_ff.s2[SY_CPUV] | (st_ff.cpuvf & ~clear_any);
    nxt_st.ovf   = (st_ff.s2[SY_OV] & ov_en) | (st_ff.ovf & ~clear_any);
    nxt_st.bkuvf = st_ff.s2[SY_BKUV] | (st_ff.bkuvf & ~clear_any);
    nxt_st.bkocf = st_ff.s2[SY_BKOC] | (st_ff.bkocf & ~clear_any);
    nxt_st.serf  = (serial_err_in & ~st_ff.ctrl[CTRL_SER_DIS]) | (st_ff.serf & ~clear_any);
    nxt_st.otpf  = st_ff.s2[SY_OTP] | (st_ff.otpf & ~slp_clr);
    nxt_st.otwf  = (st_ff.s2[SY_OTW] & st_ff.ctrl[CTRL_THERMAL_WARNING_REPORT_EN]) | (st_ff.otwf & ~clear_any);
    nxt_st.otsf  = st_ff.s2[SY_OTSD] | (st_ff.otsf & ~clear_any);

    if (ocp_any && overcurrent_response_sel != RESP_NONE) begin
      nxt_st.ocpf = 1'b1;
      nxt_st.fetf = st_ff.fetf | st_ff.s2[SY_OCP +: 6];
    end else if (clear_any) begin
      nxt_st.ocpf = 1'b0;
      nxt_st.fetf = 6'h00;
    end

    case (st_ff.ocp_st)
      P_OK: begin
        nxt_st.ocp_cnt = 32'd0;
        if (ocp_any) begin
          case (overcurrent_response_sel)
            RESP_LATCH:  nxt_st.ocp_st = P_LATCH;
            RESP_RETRY:  nxt_st.ocp_st = P_RETRY;
            RESP_REPORT: nxt_st.ocp_st = P_REPORT;
            default:     nxt_st.ocp_st = P_OK;
          endcase
        end
      end
      P_RETRY: begin
        nxt_st.ocp_cnt = st_ff.ocp_cnt + 32'd1;
        if (st_ff.ocp_cnt >= 32'(RETRY_CYCLES - 1)) nxt_st.ocp_st = P_OK;
      end
      default: begin
        if (!ocp_any && clear_any) nxt_st.ocp_st = P_OK;
      end
    endcase

    // Hall activity watchdog while driving
    if (hall_edge || st_ff.hiz || !st_ff.logic_en || lk_evt) begin
      nxt_st.stall_cnt = 32'd0;
    end else begin
      nxt_st.stall_cnt = st_ff.stall_cnt + 32'd1;
    end
    if (lk_evt && lk_mode != RESP_NONE) begin
      nxt_st.lockf = 1'b1;
    end else if (clear_any) begin
      nxt_st.lockf = 1'b0;
    end

    case (st_ff.lk_st)
      P_OK: begin
        nxt_st.lk_cnt = 32'd0;
        if (lk_evt) begin
          case (lk_mode)
            RESP_LATCH:  nxt_st.lk_st = P_LATCH;
            RESP_RETRY:  nxt_st.lk_st = P_RETRY;
            RESP_REPORT: nxt_st.lk_st = P_REPORT;
            default:     nxt_st.lk_st = P_OK;
          endcase
        end
      end
      P_RETRY: begin
        nxt_st.lk_cnt = st_ff.lk_cnt + 32'd1;
        if (st_ff.lk_cnt >= 32'(LK_RETRY_CYCLES - 1)) nxt_st.lk_st = P_OK;
      end
      default: begin
        if (clear_any) nxt_st.lk_st = P_OK;
      end
    endcase

    if (st_ff.bk_retry) begin
      nxt_st.bk_cnt = st_ff.bk_cnt + 32'd1;
      if (st_ff.bk_cnt >= 32'(RETRY_CYCLES - 1)) nxt_st.bk_retry = 1'b0;
    end else if (st_ff.s2[SY_BKOC]) begin
      nxt_st.bk_retry = 1'b1;
      nxt_st.bk_cnt   = 32'd0;
    end

    nxt_st.logic_en = ~logic_off;
    nxt_st.pump_en  = ~logic_off;
    nxt_st.reg_en   = ~logic_off & ~st_ff.s2[SY_BKUV] & ~nxt_st.bk_retry;
    nxt_st.hiz = logic_off | st_ff.s2[SY_CPUV] | (st_ff.s2[SY_OV] & ov_en)
               | nxt_st.ocp_st == P_LATCH | nxt_st.ocp_st == P_RETRY
               | nxt_st.lk_st == P_LATCH | nxt_st.lk_st == P_RETRY
               | nxt_st.otpf | st_ff.s2[SY_OTSD];
    nxt_st.fault_n = ~(st_ff.s2[SY_CPUV] | (st_ff.s2[SY_OV] & ov_en)
               | st_ff.s2[SY_BKUV] | nxt_st.bk_retry | nxt_st.serf | nxt_st.otpf
               | nxt_st.ocp_st != P_OK | nxt_st.lk_st != P_OK
               | (st_ff.s2[SY_OTW] & st_ff.ctrl[CTRL_THERMAL_WARNING_REPORT_EN]) | st_ff.s2[SY_OTSD]);
    nxt_st.adv = hw ? st_ff.s2[SY_ADV +: 3] : st_ff.ctrl[CTRL_ADV_LSB +: 3];
  end

  // State register, constants only under reset
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff          <= '0;
      st_ff.awrdy    <= 1'b1;
      st_ff.wrdy     <= 1'b1;
      st_ff.arrdy    <= 1'b1;
      st_ff.ctrl     <= CTRL_RESET;
      st_ff.hiz      <= 1'b1;
      st_ff.fault_n  <= 1'b1;
      st_ff.s1[SY_SLP] <= 1'b1;
      st_ff.s2[SY_SLP] <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready_out = st_ff.awrdy;
  assign s_axi_wready_out  = st_ff.wrdy;
  assign s_axi_bvalid_out  = st_ff.bvalid;
  assign s_axi_bresp_out   = st_ff.bresp;
  assign s_axi_arready_out = st_ff.arrdy;
  assign s_axi_rvalid_out  = st_ff.rvalid;
  assign s_axi_rresp_out   = st_ff.rresp;
  assign s_axi_rdata_out   = st_ff.rdata;
  assign bridge_hiz_out    = st_ff.hiz;
  assign pump_en_out       = st_ff.pump_en;
  assign logic_en_out      = st_ff.logic_en;
  assign regulator_en_out  = st_ff.reg_en;
  assign fault_out_n       = st_ff.fault_n;
  assign advance_angle_out = st_ff.adv;

  // Checks on the fault responses
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  uv_off_a: assert property (st_ff.s2[SY_VMUV] |=> !logic_en_out && !pump_en_out && bridge_hiz_out)
    else $error("undervoltage left drive on");
  rail_resume_a: assert property ($fell(logic_off) |=> logic_en_out)
    else $error("logic did not resume");
  power_on_status_bit_low_a: assert property (logic_off |=> !st_ff.power_on_status_bit ##1 (!st_ff.power_on_status_bit || $past(clear_any)))
    else $error("power-on bit not latched low");
  pump_uv_a: assert property (st_ff.s2[SY_CPUV] |=> bridge_hiz_out && !fault_out_n && st_ff.cpuvf)
    else $error("pump undervoltage response wrong");
  ov_quiet_a: assert property ($rose(st_ff.ovf) |-> $past(ov_en))
    else $error("overvoltage reported while disabled");
  ov_hiz_a: assert property (st_ff.s2[SY_OV] && ov_en |=> bridge_hiz_out && !fault_out_n)
    else $error("overvoltage response wrong");
  ocp_retry_a: assert property (st_ff.ocp_st == P_RETRY |-> bridge_hiz_out && !fault_out_n)
    else $error("overcurrent retry not in Hi-Z");
  ocp_latch_a: assert property (st_ff.ocp_st == P_LATCH && !clear_any |=> st_ff.ocp_st == P_LATCH)
    else $error("overcurrent latch released early");
  reg_ocp_a: assert property (st_ff.s2[SY_BKOC] && !st_ff.bk_retry |=> !fault_out_n && !regulator_en_out)
    else $error("regulator overcurrent not reported");
  ser_err_a: assert property (serial_err_in && !st_ff.ctrl[CTRL_SER_DIS] |=> st_ff.serf && !fault_out_n)
    else $error("serial error not reported");
  otp_hold_a: assert property (st_ff.otpf && !slp_clr |=> st_ff.otpf && bridge_hiz_out)
    else $error("memory error released early");
  ots_hiz_a: assert property (st_ff.s2[SY_OTSD] |=> bridge_hiz_out && st_ff.otsf)
    else $error("thermal shutdown not in Hi-Z");
  reg_uv_a: assert property (st_ff.s2[SY_BKUV] |=> !regulator_en_out && !fault_out_n)
    else $error("regulator undervoltage response wrong");

  ocp_retry_c: cover property (st_ff.ocp_st == P_RETRY ##1 st_ff.ocp_st == P_OK);
  lock_trip_c: cover property (lk_evt && lk_mode == RESP_LATCH);
  sleep_clr_c: cover property (slp_clr && st_ff.otpf);
  axi_write_c: cover property (st_ff.bvalid && s_axi_bready_in);

endmodule

// file: tb/host_model.sv
// Host side of the fault manager: pull-ups on the open-drain pins.
// Assumes enables are high while the device pulls a pin low.
`timescale 1ns/100ps
module host_model (
  // Pin drives from the device
  input  wire logic fault_n_in,
  input  wire logic speed_oe_in,
  // Pin levels as the host sees them
  output logic      fault_pin_out,
  output logic      speed_pin_out
);
  assign fault_pin_out = fault_n_in;
  assign speed_pin_out = speed_oe_in ? 1'b0 : 1'b1;
endmodule

// file: tb/test_motor_driver_fault_manager.sv
// Bench for the fault manager: bus tasks, fault stimulus, read notes.
// Assumes retry and stall counts are shortened through parameters.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module test_motor_driver_fault_manager;
  import mtr_fault_pkg::*;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, hiz, fault_n, spd_oe;
  logic        fault_pin, speed_pin;
  logic        ser, pump_en, logic_en, reg_en, rnd, sp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [9:0]  cmp;
  logic [5:0]  ocp;
  logic [2:0]  hall, adv_out, hset;
  logic [11:0] base;
  logic [65:0] notes[$];
  logic [65:0] nt;
  int          mismatches, comparisons, seed, m;

  mtr_fault_mgr #(.RETRY_CYCLES(20), .LK_RETRY_CYCLES(20), .LK_DET_CYCLES(50)) uut (
    .clk_sys_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .cmp_in(cmp), .fet_ocp_in(ocp), .adv_level_in(3'h0), .hw_variant_in(1'b0),
    .hall_in(hall), .serial_err_in(ser), .bridge_hiz_out(hiz), .pump_en_out(pump_en),
    .logic_en_out(logic_en), .regulator_en_out(reg_en), .fault_out_n(fault_n),
    .advance_angle_out(adv_out), .speed_pulse_oe_out(spd_oe));
  host_model host (.fault_n_in(fault_n), .speed_oe_in(spd_oe),
    .fault_pin_out(fault_pin), .speed_pin_out(speed_pin));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random Hall levels keep the stall watchdog quiet; fixed levels when frozen
  always @(posedge clk) hall <= rnd ? 3'($random(seed)) : hset;

  // Write responses, and read results against the oldest note
  always @(negedge clk) begin
    if (bvalid && bready) `CHK(bresp, 2'b00)
    if (rvalid && rready && notes.size() > 0) begin
      nt = notes.pop_front();
      `CHK({rresp, rdata & nt[63:32]}, {nt[65:64], nt[31:0]})
    end
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task step(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Bus write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) begin mismatches++; report_and_stop(); end
  endtask

  // Bus read, expected response and masked data noted first
  task rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] mk, ex);
    int n;
    logic ta, tr;
    tr = 1'b0;
    notes.push_back({rs, mk, ex});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !tr; n++) begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) begin mismatches++; report_and_stop(); end
  endtask

  task pins(input logic h, f);
    @(negedge clk);
    `CHK(hiz, h)
    `CHK(fault_pin, f)
  endtask

  // Main sequence
  initial begin
    seed = 18284;
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ocp, hset, ser} = '0;
    rnd = 1'b1;
    cmp = 10'h200;
    base = 12'ha60;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_STATUS, 2'b00, 32'h1, 32'h0);
    wr(ADDR_CTRL, {20'h0, base});
    rd(ADDR_CTRL, 2'b00, 32'hfff, {20'h0, base});
    step(4);
    `CHK(adv_out, 3'd5)
    rd(8'h40, 2'b10, 32'hffff_ffff, 32'h0);
    wr(ADDR_CLEAR, 32'h1);
    rd(ADDR_STATUS, 2'b00, 32'h1, 32'h1);
    pins(1'b0, 1'b1);
    $display("test done: registers");
    @(posedge clk) cmp[3] <= 1'b1;
    step(5);
    pins(1'b1, 1'b0);
    @(posedge clk) cmp[3] <= 1'b0;
    step(5);
    pins(1'b0, 1'b1);
    rd(ADDR_STATUS, 2'b00, 32'h2, 32'h2);
    @(posedge clk) cmp[4] <= 1'b1;
    step(5);
    pins(1'b0, 1'b1);
    rd(ADDR_STATUS, 2'b00, 32'h4, 32'h0);
    wr(ADDR_CTRL, {20'h0, base | 12'h001});
    step(5);
    pins(1'b1, 1'b0);
    @(posedge clk) cmp[4] <= 1'b0;
    step(5);
    pins(1'b0, 1'b1);
    rd(ADDR_STATUS, 2'b00, 32'h4, 32'h4);
    $display("test done: supply faults");
    for (m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, {20'h0, base | 12'(m << 3)});
      wr(ADDR_CLEAR, 32'h1);
      @(posedge clk) ocp <= 6'h01;
      step(5);
      pins(m < 2, m == 3);
      @(posedge clk) ocp <= 6'h00;
      step(30);
      pins(m == 0, m == 1 || m == 3);
      rd(ADDR_STATUS, 2'b00, 32'h1008, (m < 3) ? 32'h1008 : 32'h0);
      wr(ADDR_CLEAR, 32'h1);
      step(3);
      pins(1'b0, 1'b1);
    end
    $display("test done: overcurrent modes");
    // Frozen Hall levels for speed and stall checks
    rnd <= 1'b0;
    step(8);
    @(negedge clk) sp = speed_pin;
    @(posedge clk) hset <= 3'h3;
    step(6);
    @(negedge clk) `CHK(speed_pin, ~sp)
    wr(ADDR_CTRL, {20'h0, base | 12'h080});
    @(posedge clk) hset <= 3'h2;
    step(6);
    @(negedge clk) `CHK(speed_pin, ~sp)
    @(posedge clk) hset <= 3'h6;
    step(6);
    @(negedge clk) `CHK(speed_pin, sp)
    wr(ADDR_CTRL, {20'h0, base & 12'hf9f});
    step(60);
    pins(1'b1, 1'b0);
    rd(ADDR_STATUS, 2'b00, 32'h100, 32'h100);
    rnd <= 1'b1;
    wr(ADDR_CTRL, {20'h0, base});
    wr(ADDR_CLEAR, 32'h1);
    step(3);
    pins(1'b0, 1'b1);
    $display("test done: speed and stall");
    @(posedge clk) cmp[0] <= 1'b1;
    step(5);
    pins(1'b1, 1'b1);
    @(negedge clk) `CHK({logic_en, pump_en}, 2'b00)
    @(posedge clk) cmp[1:0] <= 2'b10;
    step(5);
    @(negedge clk) `CHK({logic_en, hiz}, 2'b01)
    @(posedge clk) cmp[1] <= 1'b0;
    step(5);
    @(negedge clk) `CHK({logic_en, pump_en, hiz}, 3'b110)
    rd(ADDR_STATUS, 2'b00, 32'h1, 32'h0);
    @(posedge clk) cmp[2] <= 1'b1;
    step(5);
    pins(1'b0, 1'b0);
    @(negedge clk) `CHK(reg_en, 1'b0)
    @(posedge clk) {cmp[8], cmp[2]} <= 2'b10;
    step(5);
    pins(1'b0, 1'b0);
    @(negedge clk) `CHK(reg_en, 1'b0)
    @(posedge clk) cmp[8] <= 1'b0;
    step(30);
    pins(1'b0, 1'b1);
    @(negedge clk) `CHK(reg_en, 1'b1)
    @(posedge clk) ser <= 1'b1;
    @(posedge clk) ser <= 1'b0;
    @(posedge clk) cmp[7] <= 1'b1;
    step(5);
    pins(1'b1, 1'b0);
    @(posedge clk) cmp[7] <= 1'b0;
    step(5);
    pins(1'b0, 1'b0);
    @(posedge clk) cmp[5] <= 1'b1;
    @(posedge clk) cmp[5] <= 1'b0;
    step(3);
    rd(ADDR_STATUS, 2'b00, 32'h4c0, 32'h4c0);
    wr(ADDR_CLEAR, 32'h1);
    step(3);
    pins(1'b1, 1'b0);
    rd(ADDR_STATUS, 2'b00, 32'h4c0, 32'h080);
    @(posedge clk) cmp[9] <= 1'b0;
    step(110);
    @(posedge clk) cmp[9] <= 1'b1;
    step(5);
    pins(1'b0, 1'b1);
    rd(ADDR_STATUS, 2'b00, 32'h81, 32'h1);
    @(posedge clk) cmp[6] <= 1'b1;
    step(5);
    pins(1'b0, 1'b1);
    wr(ADDR_CTRL, {20'h0, base | 12'h004});
    step(5);
    pins(1'b0, 1'b0);
    @(posedge clk) cmp[6] <= 1'b0;
    step(5);
    pins(1'b0, 1'b1);
    rd(ADDR_STATUS, 2'b00, 32'h200, 32'h200);
    $display("test done: rail and pin faults");
    report_and_stop();
  end
endmodule
